/* File: hdl/nab_cfg.svh */
`ifndef NAB_CFG_SVH
`define NAB_CFG_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define NAB_OFF_CTRL 8'h00
`define NAB_OFF_STATUS 8'h04
`define NAB_OFF_CMD 8'h08
`define NAB_OFF_ADDR_LO 8'h0C
`define NAB_OFF_ADDR_HI 8'h10
`define NAB_OFF_DATA 8'h14
`define NAB_OFF_READ 8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define NAB_CTRL_TARGET 0
`define NAB_CTRL_GUARD 1
`define NAB_CTRL_LATE 2
`define NAB_CTRL_WAIT 3
`define NAB_STAT_BUSY 0
`define NAB_STAT_RB 1
`define NAB_STAT_PERDIE 2
`define NAB_STAT_ERR 3
`define NAB_STAT_DATA_LSB 8
`define NAB_LO_COL_LSB 0
`define NAB_LO_PAGE_LSB 16
`define NAB_HI_BLOCK_LSB 0
`define NAB_HI_DIE 20
`define NAB_READ_ARRAY 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define NAB_CTRL_RESET 4'h0

// ----------------------------------------------------------------
// command codes and address limits
// ----------------------------------------------------------------
`define NAB_CMD_STATUS 8'h70
`define NAB_CMD_STATUS_DIE 8'h78
`define NAB_CMD_RETURN 8'h00
`define NAB_COL_LIMIT 13'h10E0
`define NAB_ADDR_BYTES 5

// ----------------------------------------------------------------
// timing, in ns and derived clock counts
// ----------------------------------------------------------------
`define NAB_CLK_NS 10
`define NAB_T_CYCLE_NS 30
`define NAB_T_LOW_NS 15
`define NAB_T_LATE_LIMIT_NS 30
`define NAB_LOW_CYC \
  ((`NAB_T_LOW_NS + `NAB_CLK_NS - 1) / `NAB_CLK_NS)
`define NAB_HIGH_CYC \
  ((`NAB_T_CYCLE_NS - `NAB_T_LOW_NS + `NAB_CLK_NS - 1) / `NAB_CLK_NS)

`endif

/* File: hdl/nab_pkg.sv */
package nab_pkg;

  // strobe phase of one bus cycle
  typedef enum logic [2:0] {
    NAB_PH_IDLE = 3'b001,
    NAB_PH_LOW = 3'b010,
    NAB_PH_HIGH = 3'b100
  } nab_phase_e;

  // operation sequencer states
  typedef enum logic [6:0] {
    NAB_S_IDLE = 7'b0000001,
    NAB_S_WAITRDY = 7'b0000010,
    NAB_S_CMD = 7'b0000100,
    NAB_S_ADDR = 7'b0001000,
    NAB_S_WDATA = 7'b0010000,
    NAB_S_PRECMD = 7'b0100000,
    NAB_S_RDATA = 7'b1000000
  } nab_state_e;

  // control pins toward the flash targets
  typedef struct packed {
    logic [1:0] target_select_n;
    logic command_latch_strobe;
    logic address_latch_strobe;
    logic write_strobe_n;
    logic read_strobe_n;
  } nab_pins_s;

  // full array address
  typedef struct packed {
    logic die_select_bit;
    logic [19:0] block_bits;
    logic [7:0] page_bits;
    logic [12:0] column_bits;
  } nab_addr_s;

endpackage

/* File: hdl/nab_addr_pack.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nab_cfg.svh"

module nab_addr_pack #(
  parameter bit DUAL_DIE = 1'b0
) (
  input wire nab_pkg::nab_addr_s addr,
  output logic [4:0][7:0] addr_bytes,
  output logic out_of_range
);
  import nab_pkg::*;

  // ----------------------------------------------------------------
  // five address bytes, unused upper bits forced low
  // ----------------------------------------------------------------
  always_comb begin
    addr_bytes[0] = addr.column_bits[7:0];
    addr_bytes[1] = {3'h0, addr.column_bits[12:8]};
    addr_bytes[2] = addr.page_bits;
    addr_bytes[3] = addr.block_bits[15:8];
    addr_bytes[4] = {3'h0, addr.die_select_bit & DUAL_DIE,
      addr.block_bits[19:16]};
  end

  // columns past the page do not exist
  assign out_of_range = (addr.column_bits >= `NAB_COL_LIMIT);

endmodule
`default_nettype wire

/* File: hdl/nab_cycle_gen.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nab_cfg.svh"

module nab_cycle_gen #(
  parameter int LOW_CYC = `NAB_LOW_CYC,
  parameter int HIGH_CYC = `NAB_HIGH_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire logic is_read,
  input wire logic late_sample,
  input wire logic [7:0] wbyte,
  input wire logic [7:0] dq_in,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic [7:0] dq_out,
  output logic dq_oe_n,
  output logic done,
  output logic [7:0] rbyte
);
  import nab_pkg::*;

  nab_phase_e phase;
  logic [7:0] cnt;
  logic rd;

  // ----------------------------------------------------------------
  // strobe timing: low phase then high phase
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      phase <= NAB_PH_IDLE;
      cnt <= 8'h00;
      rd <= 1'b0;
      write_strobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (phase)
        NAB_PH_IDLE: begin
          if (start) begin
            rd <= is_read;
            write_strobe_n <= is_read;
            read_strobe_n <= ~is_read;
            cnt <= 8'(LOW_CYC - 1);
            phase <= NAB_PH_LOW;
          end
        end
        NAB_PH_LOW: begin
          if (cnt == 8'h00) begin
            write_strobe_n <= 1'b1; // rising edge latches the byte
            read_strobe_n <= 1'b1;
            cnt <= 8'(HIGH_CYC - 1);
            phase <= NAB_PH_HIGH;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        NAB_PH_HIGH: begin
          if (cnt == 8'h00) begin
            done <= 1'b1;
            phase <= NAB_PH_IDLE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        default: phase <= NAB_PH_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // host drives the bus only for write cycles
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dq_out <= 8'h00;
      dq_oe_n <= 1'b1;
    end else if (phase == NAB_PH_IDLE && start) begin
      dq_out <= wbyte;
      dq_oe_n <= is_read;
    end else if (phase == NAB_PH_HIGH && cnt == 8'h00) begin
      dq_oe_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // sample point: at the rise, or late in extended output timing
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rbyte <= 8'h00;
    end else if (rd && !late_sample && phase == NAB_PH_LOW
        && cnt == 8'h00) begin
      rbyte <= dq_in;
    end else if (rd && late_sample && phase == NAB_PH_HIGH
        && cnt == 8'h00) begin
      rbyte <= dq_in;
    end
  end

endmodule
`default_nettype wire

/* File: hdl/nab_host.sv */
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "nab_cfg.svh"

module nab_host #(
  parameter bit DUAL_DIE = 1'b0,
  parameter int T_CYCLE_NS = `NAB_T_CYCLE_NS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output nab_pkg::nab_pins_s pins,
  output logic program_guard_n,
  input wire logic ready_busy_n,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe_n,
  input wire logic data_strobe_in,
  output logic data_strobe_out,
  output logic data_strobe_oe_n
);
  import nab_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  nab_state_e state;
  logic [3:0] ctrl;
  logic [31:0] addr_lo;
  nab_addr_s addr;
  logic [4:0][7:0] addr_bytes;
  logic out_of_range;
  logic [2:0] byte_idx;
  logic [7:0] cmd_byte;
  logic [7:0] wr_byte;
  logic [7:0] read_data;
  logic array_read;
  logic per_die_mode;
  logic err;
  logic gen_start;
  logic gen_is_read;
  logic [7:0] gen_wbyte;
  logic gen_done;
  logic [7:0] gen_rbyte;
  logic gen_we_n;
  logic gen_rd_n;
  logic wr_access;
  logic engine_busy;
  logic start_reg;
  logic mapped;
  logic late_on;
  logic need_ready;
  logic [31:0] next_prdata;
  logic start_d;
  logic [1:0] sel_n;
  logic cle;
  logic ale;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign engine_busy = (state != NAB_S_IDLE);
  assign start_reg = (paddr == `NAB_OFF_CMD) || (paddr == `NAB_OFF_ADDR_HI)
    || (paddr == `NAB_OFF_DATA) || (paddr == `NAB_OFF_READ);
  assign mapped = start_reg || (paddr == `NAB_OFF_CTRL)
    || (paddr == `NAB_OFF_STATUS) || (paddr == `NAB_OFF_ADDR_LO);
  // starting writes stall while an operation runs
  assign pready = !(pwrite && start_reg && engine_busy);
  assign pslverr = psel && penable && !mapped;
  assign wr_access = psel && penable && pwrite && pready && mapped;

  // short read cycles force late sampling
  assign late_on = ctrl[`NAB_CTRL_LATE]
    || (T_CYCLE_NS < `NAB_T_LATE_LIMIT_NS);

  // status reads may go to a busy die; others wait for ready only when the wait bit is set
  assign need_ready = ctrl[`NAB_CTRL_WAIT]
    && (pwdata[7:0] != `NAB_CMD_STATUS)
    && (pwdata[7:0] != `NAB_CMD_STATUS_DIE);

  // ----------------------------------------------------------------
  // read data mux, registered in the setup phase
  // ----------------------------------------------------------------
  always_comb begin
    next_prdata = 32'h00000000;
    case (paddr)
      `NAB_OFF_CTRL: next_prdata[3:0] = ctrl;
      `NAB_OFF_STATUS: begin
        next_prdata[`NAB_STAT_BUSY] = engine_busy;
        next_prdata[`NAB_STAT_RB] = ready_busy_n;
        next_prdata[`NAB_STAT_PERDIE] = per_die_mode;
        next_prdata[`NAB_STAT_ERR] = err;
        next_prdata[`NAB_STAT_DATA_LSB +: 8] = read_data;
      end
      `NAB_OFF_ADDR_LO: next_prdata = addr_lo;
      `NAB_OFF_ADDR_HI: next_prdata[20:0] = {addr.die_select_bit,
        addr.block_bits};
      `NAB_OFF_DATA: next_prdata[7:0] = read_data;
      default: next_prdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // control and address registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl <= `NAB_CTRL_RESET;
    end else if (wr_access && paddr == `NAB_OFF_CTRL) begin
      ctrl <= pwdata[3:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      addr_lo <= 32'h00000000;
      addr <= '0;
    end else if (wr_access && paddr == `NAB_OFF_ADDR_LO) begin
      addr_lo <= {8'h00, pwdata[`NAB_LO_PAGE_LSB +: 8], 3'h0,
        pwdata[`NAB_LO_COL_LSB +: 13]};
      addr.column_bits <= pwdata[`NAB_LO_COL_LSB +: 13];
      addr.page_bits <= pwdata[`NAB_LO_PAGE_LSB +: 8];
    end else if (wr_access && paddr == `NAB_OFF_ADDR_HI) begin
      addr.block_bits <= pwdata[`NAB_HI_BLOCK_LSB +: 20];
      addr.die_select_bit <= pwdata[`NAB_HI_DIE];
    end
  end

  // guard pin follows software, active even while deselected
  assign program_guard_n = ctrl[`NAB_CTRL_GUARD];

  // ----------------------------------------------------------------
  // error flag: out-of-page column, write one to clear
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      err <= 1'b0;
    end else if (wr_access && paddr == `NAB_OFF_ADDR_HI && !engine_busy
        && out_of_range) begin
      err <= 1'b1;
    end else if (wr_access && paddr == `NAB_OFF_STATUS
        && pwdata[`NAB_STAT_ERR]) begin
      err <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // per-die status mode: set by 78h, cleared by 00h
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      per_die_mode <= 1'b0;
    end else if (gen_done && (state == NAB_S_CMD
        || state == NAB_S_PRECMD)) begin
      if (cmd_byte == `NAB_CMD_STATUS_DIE) begin
        per_die_mode <= 1'b1;
      end else if (cmd_byte == `NAB_CMD_RETURN) begin
        per_die_mode <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // operation sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= NAB_S_IDLE;
      byte_idx <= 3'h0;
      cmd_byte <= 8'h00;
      wr_byte <= 8'h00;
      array_read <= 1'b0;
      gen_start <= 1'b0;
      start_d <= 1'b0;
    end else begin
      gen_start <= 1'b0;
      // one cycle late: select and latch strobes settle before a fall
      start_d <= gen_start;
      case (state)
        NAB_S_IDLE: begin
          if (wr_access && paddr == `NAB_OFF_CMD) begin
            cmd_byte <= pwdata[7:0];
            if (need_ready && !ready_busy_n) begin
              state <= NAB_S_WAITRDY;
            end else begin
              gen_start <= 1'b1;
              state <= NAB_S_CMD;
            end
          end else if (wr_access && paddr == `NAB_OFF_ADDR_HI
              && !out_of_range) begin
            byte_idx <= 3'h0;
            gen_start <= 1'b1;
            state <= NAB_S_ADDR;
          end else if (wr_access && paddr == `NAB_OFF_DATA) begin
            wr_byte <= pwdata[7:0];
            gen_start <= 1'b1;
            state <= NAB_S_WDATA;
          end else if (wr_access && paddr == `NAB_OFF_READ) begin
            array_read <= pwdata[`NAB_READ_ARRAY];
            gen_start <= 1'b1;
            if (pwdata[`NAB_READ_ARRAY] && per_die_mode) begin
              cmd_byte <= `NAB_CMD_RETURN;
              state <= NAB_S_PRECMD;
            end else begin
              state <= NAB_S_RDATA;
            end
          end
        end
        NAB_S_WAITRDY: begin
          if (ready_busy_n) begin
            gen_start <= 1'b1;
            state <= NAB_S_CMD;
          end
        end
        NAB_S_CMD: begin
          if (gen_done) begin
            state <= NAB_S_IDLE;
          end
        end
        NAB_S_ADDR: begin
          if (gen_done) begin
            if (byte_idx == 3'(`NAB_ADDR_BYTES - 1)) begin
              state <= NAB_S_IDLE;
            end else begin
              byte_idx <= byte_idx + 3'h1;
              gen_start <= 1'b1;
            end
          end
        end
        NAB_S_WDATA: begin
          if (gen_done) begin
            state <= NAB_S_IDLE;
          end
        end
        NAB_S_PRECMD: begin
          if (gen_done) begin
            gen_start <= 1'b1;
            state <= NAB_S_RDATA;
          end
        end
        NAB_S_RDATA: begin
          if (gen_done) begin
            state <= NAB_S_IDLE;
          end
        end
        default: state <= NAB_S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // captured read byte
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      read_data <= 8'h00;
    end else if (gen_done && state == NAB_S_RDATA) begin
      read_data <= gen_rbyte;
    end
  end

  // ----------------------------------------------------------------
  // byte and direction for the cycle generator
  // ----------------------------------------------------------------
  always_comb begin
    gen_is_read = (state == NAB_S_RDATA);
    case (state)
      NAB_S_CMD: gen_wbyte = cmd_byte;
      NAB_S_PRECMD: gen_wbyte = cmd_byte;
      NAB_S_ADDR: gen_wbyte = addr_bytes[byte_idx];
      NAB_S_WDATA: gen_wbyte = wr_byte;
      default: gen_wbyte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // pin levels: one select per target, strobes idle high
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sel_n <= 2'b11;
      cle <= 1'b0;
      ale <= 1'b0;
    end else begin
      // selects raised when idle or waiting for ready so the target may enter standby
      sel_n <= 2'b11;
      if (state != NAB_S_IDLE && state != NAB_S_WAITRDY) begin
        sel_n[ctrl[`NAB_CTRL_TARGET]] <= 1'b0;
      end
      cle <= (state == NAB_S_CMD) || (state == NAB_S_PRECMD);
      ale <= (state == NAB_S_ADDR);
    end
  end

  // strobes come straight from the generator: both high between cycles
  assign pins = {sel_n, cle, ale, gen_we_n, gen_rd_n};

  // data strobe is left undriven in asynchronous mode
  assign data_strobe_out = 1'b0;
  assign data_strobe_oe_n = 1'b1;

  // ----------------------------------------------------------------
  // sub-blocks
  // ----------------------------------------------------------------
  nab_addr_pack #(
    .DUAL_DIE(DUAL_DIE)
  ) u_addr (
    .addr(addr),
    .addr_bytes(addr_bytes),
    .out_of_range(out_of_range)
  );

  nab_cycle_gen #(
    .LOW_CYC(`NAB_LOW_CYC),
    .HIGH_CYC((T_CYCLE_NS - `NAB_T_LOW_NS + `NAB_CLK_NS - 1) / `NAB_CLK_NS)
  ) u_gen (
    .clock(clock),
    .rst_n(rst_n),
    .start(start_d),
    .is_read(gen_is_read),
    .late_sample(late_on),
    .wbyte(gen_wbyte),
    .dq_in(dq_in),
    .write_strobe_n(gen_we_n),
    .read_strobe_n(gen_rd_n),
    .dq_out(dq_out),
    .dq_oe_n(dq_oe_n),
    .done(gen_done),
    .rbyte(gen_rbyte)
  );

endmodule
`default_nettype wire

/* File: test/nab_host_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module nab_host_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire nab_pkg::nab_pins_s pins,
  input wire logic dq_oe_n,
  input wire logic data_strobe_oe_n
);
  import nab_pkg::*;
  // ------------------------------------------------------------
  // bus mode checks
  // ------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  strobe_excl_a: assert property (
    pins.write_strobe_n || pins.read_strobe_n) else $error("both strobes low");
  latch_excl_a: assert property (!pins.write_strobe_n |->
    !(pins.command_latch_strobe && pins.address_latch_strobe))
    else $error("both latch strobes high");
  sel_one_a: assert property ($onehot0(~pins.target_select_n))
    else $error("two targets selected");
  strobe_sel_a: assert property (!(pins.write_strobe_n &&
    pins.read_strobe_n) |-> pins.target_select_n != 2'b11)
    else $error("strobe without select");
  setup_hold_a: assert property ($fell(pins.write_strobe_n) |->
    $stable(pins.target_select_n) && $stable(pins.address_latch_strobe))
    else $error("select moved at strobe fall");
  we_pulse_a: assert property ($fell(pins.write_strobe_n) |->
    ##1 !pins.write_strobe_n ##1 pins.write_strobe_n [*2])
    else $error("write pulse shape");
  read_mode_a: assert property (!pins.read_strobe_n |->
    !pins.command_latch_strobe && !pins.address_latch_strobe && dq_oe_n)
    else $error("read cycle mode");
  write_drive_a: assert property (!pins.write_strobe_n |-> !dq_oe_n)
    else $error("bus not driven on write");
  dqs_off_a: assert property (data_strobe_oe_n)
    else $error("data strobe driven");
  cover property (!pins.write_strobe_n && pins.command_latch_strobe);
  cover property (!pins.write_strobe_n && pins.address_latch_strobe);
  cover property (!pins.read_strobe_n);
endmodule
bind nab_host nab_host_chk u_chk (.clock(clock), .rst_n(rst_n),
  .pins(pins), .dq_oe_n(dq_oe_n), .data_strobe_oe_n(data_strobe_oe_n));
`default_nettype wire

/* File: test/nab_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module nab_flash_model #(
  parameter int SEL = 0
) (
  input wire nab_pkg::nab_pins_s pins,
  input wire logic [7:0] bus,
  input wire logic busy,
  output logic [7:0] dq,
  output logic ready_busy_n
);
  import nab_pkg::*;
  // ------------------------------------------------------------
  // one target with a small cache
  // ------------------------------------------------------------
  logic sel, stat_mode = 1'b0, per_die = 1'b0, loaded = 1'b0, drive = 1'b0;
  logic [7:0] last_cmd = 8'h00, out = 8'h00;
  logic [7:0] abyte [5];
  logic [7:0] cache [8];
  int na = 0, wp = 0, rp = 0;
  assign sel = !pins.target_select_n[SEL];
  assign ready_busy_n = busy ? 1'b0 : 1'b1;
  assign dq = drive ? out : ~out;
  // latch cycles on write strobe rise
  always @(posedge pins.write_strobe_n) if (sel && pins.read_strobe_n) begin
    if (pins.command_latch_strobe && !pins.address_latch_strobe) begin
      if (!busy || bus == 8'h70 || bus == 8'h78) begin
        last_cmd = bus;
        na = 0;
        stat_mode = bus == 8'h70 || bus == 8'h78;
        if (bus == 8'h78) per_die = 1'b1;
        if (bus == 8'h00) per_die = 1'b0;
        if (bus == 8'h30) loaded = 1'b1;
      end
    end else if (pins.address_latch_strobe) begin
      if (!busy || last_cmd == 8'h78) begin
        abyte[na % 5] = bus;
        na++;
        wp = 0;
        rp = 0;
      end
    end else if (!pins.command_latch_strobe && !busy) begin
      cache[wp] = bus;
      wp = (wp + 1) % 8;
    end
  end
  // output byte on read strobe fall
  always @(negedge pins.read_strobe_n) if (sel && pins.write_strobe_n &&
      !pins.command_latch_strobe && !pins.address_latch_strobe) begin
    drive = 1'b0;
    if (stat_mode) begin
      out = {1'b0, !busy, 6'h00};
      drive = 1'b1;
    end else if (!busy && loaded && !per_die) begin
      out = cache[rp];
      rp = (rp + 1) % 8;
      drive = 1'b1;
    end
  end
  // release the bus on deselect or a write
  always @(posedge pins.target_select_n[SEL] or negedge pins.write_strobe_n)
    drive = 1'b0;
endmodule
`default_nettype wire

/* File: test/nab_async_bus_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module nab_async_bus_port_tb;
  import nab_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, dev_busy = 1'b0, serr;
  logic [7:0] paddr = 8'h00, dq_in, dq_out, bus;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, program_guard_n, dq_oe_n, ready_busy_n;
  logic data_strobe_oe_n;
  nab_pins_s pins;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  // ------------------------------------------------------------
  // clock, shared bus, instances
  // ------------------------------------------------------------
  always #5 clock = ~clock;
  assign bus = dq_oe_n ? dq_in : dq_out;
  nab_host dut (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .program_guard_n(program_guard_n), .ready_busy_n(ready_busy_n),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .data_strobe_in(1'b0), .data_strobe_out(),
    .data_strobe_oe_n(data_strobe_oe_n));
  nab_flash_model mdl (.pins(pins), .bus(bus), .busy(dev_busy),
    .dq(dq_in), .ready_busy_n(ready_busy_n));
  task automatic chk(input string s, input logic [31:0] v, e);
    n_compared++;
    if (v !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", s, e, v);
    end
  endtask
  // one apb transfer, result in r and serr
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic idle;
    do apb(1'b0, 8'h04, 32'h0); while (r[0] !== 1'b0);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    chk("select", pins.target_select_n, 2'b11);
    chk("guard", program_guard_n, 1'b0);
    apb(1'b1, 8'h00, 32'h2);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", r, 32'h2);
    chk("guard on", program_guard_n, 1'b1);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {serr, r[7:0]}, 9'h100);
  endtask
  task automatic t_cmd;
    apb(1'b1, 8'h08, 32'h90);
    idle;
    chk("cmd", mdl.last_cmd, 8'h90);
    apb(1'b1, 8'h00, 32'h3);
    apb(1'b1, 8'h08, 32'h00);
    idle;
    chk("other target", mdl.last_cmd, 8'h90);
    apb(1'b1, 8'h00, 32'h2);
  endtask
  task automatic t_addr;
    apb(1'b1, 8'h08, 32'h00);
    apb(1'b1, 8'h0C, 32'h0045_0123);
    apb(1'b1, 8'h10, 32'h0015_A3C7);
    idle;
    chk("addr count", mdl.na, 5);
    chk("col lo", mdl.abyte[0], 8'h23);
    chk("col hi", mdl.abyte[1], 8'h01);
    chk("page", mdl.abyte[2], 8'h45);
    chk("plane", mdl.abyte[3], 8'hA3);
    chk("die", mdl.abyte[4], 8'h05);
    apb(1'b1, 8'h08, 32'h00);
    apb(1'b1, 8'h0C, 32'h0000_10E0);
    apb(1'b1, 8'h10, 32'h0);
    idle;
    chk("bad col", mdl.na, 0);
    chk("err", r[3], 1'b1);
    apb(1'b1, 8'h04, 32'h8);
    idle;
    chk("err clr", r[3], 1'b0);
  endtask
  task automatic t_data;
    apb(1'b1, 8'h08, 32'h30);
    apb(1'b1, 8'h0C, 32'h0);
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h14, 32'hA5);
    apb(1'b1, 8'h14, 32'h3C);
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h18, 32'h0);
    idle;
    chk("rd 0", r[15:8], 8'hA5);
    apb(1'b1, 8'h00, 32'h6);
    apb(1'b1, 8'h18, 32'h0);
    idle;
    chk("rd late", r[15:8], 8'h3C);
    apb(1'b1, 8'h00, 32'h2);
  endtask
  task automatic t_busy;
    dev_busy <= 1'b1;
    apb(1'b1, 8'h08, 32'h90);
    idle;
    chk("busy cmd", mdl.last_cmd, 8'h30);
    chk("rb pin", r[1], 1'b0);
    apb(1'b1, 8'h14, 32'h5A);
    idle;
    chk("busy data", mdl.cache[0], 8'hA5);
    apb(1'b1, 8'h08, 32'h70);
    apb(1'b1, 8'h18, 32'h0);
    idle;
    chk("busy stat", r[15:8], 8'h00);
    apb(1'b1, 8'h08, 32'h78);
    apb(1'b1, 8'h10, 32'h0);
    idle;
    chk("busy addr", mdl.na, 5);
    chk("per die", r[2], 1'b1);
    dev_busy <= 1'b0;
    apb(1'b1, 8'h18, 32'h1);
    idle;
    chk("return cmd", mdl.last_cmd, 8'h00);
    chk("array rd", r[15:8], 8'hA5);
    chk("die mode off", r[2], 1'b0);
    dev_busy <= 1'b1;
    apb(1'b1, 8'h00, 32'hA);
    apb(1'b1, 8'h08, 32'h90);
    apb(1'b0, 8'h04, 32'h0);
    chk("held cmd", {r[0], mdl.last_cmd}, 9'h100);
    chk("held select", pins.target_select_n, 2'b11);
    dev_busy <= 1'b0;
    idle;
    chk("late cmd", mdl.last_cmd, 8'h90);
  endtask
  task complete_run;
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ------------------------------------------------------------
  // sequence and hang limit
  // ------------------------------------------------------------
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run;
    end
  end
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset;
    t_cmd;
    t_addr;
    t_data;
    t_busy;
    complete_run;
  end
endmodule
`default_nettype wire
